// *** shared/rcs_pkg.sv ***
// Contract
// - watchdog enabled by config, own RC tick
// - start-up hold until oscillator settles
// - 72 ms power-up hold, power-on only; never held here, as power-on erases power_up_delay_enable to 1
// - brown-out detection forces internal reset
// - sleep wakes on reset, watchdog, interrupt
// - config bit programmed reads 0, selects
// - config word sits at location 2007h
// - config space reachable only in programming
// - config word field layout, protect on top
// - code protect never blocks core EEPROM access
// shared constants, types and register map of the supervisor
// assumes one 125 MHz clock and a 32-bit AHB-Lite register bus
package rcs_pkg;
  // own register byte addresses
  localparam logic [15:0] ADDR_CTRL   = 16'h0000;
  localparam logic [15:0] ADDR_STATUS = 16'h0004;
  localparam logic [15:0] ADDR_MASK   = 16'h0008;
  localparam logic [15:0] ADDR_STATE  = 16'h000C;
  // configuration space indices, byte address is four times these
  localparam logic [13:0] CFG_INDEX    = 14'h2007;
  localparam logic [13:0] CFG_SPACE_LO = 14'h2000;
  localparam logic [13:0] CFG_SPACE_HI = 14'h3FFF;
  localparam logic [13:0] CFG_RESET    = 14'h3FFF;  // erased: all unprogrammed
  // control bits (write one to act)
  localparam int CTRL_SLEEP = 0;
  localparam int CTRL_KICK  = 1;
  // status and mask bits
  localparam int ST_POR  = 0;
  localparam int ST_BOR  = 1;
  localparam int ST_WDT  = 2;
  localparam int ST_EXT  = 3;
  localparam int ST_WAKE = 4;
  localparam int ST_W    = 5;
  // timing
  localparam int CLK_NS     = 8;
  localparam int POWER_UP_DELAY_TIMER_MS    = 72;
  localparam int POWER_UP_DELAY_TIMER_CYC   = POWER_UP_DELAY_TIMER_MS * 1000000 / CLK_NS;
  localparam int OST_CYC    = 1024;  // plain default
  localparam int WDT_TICKS  = 2048;  // plain default, RC ticks
  localparam int CNT_W      = 24;
  // configuration word layout, bit 13 down to bit 0
  typedef struct packed {
    logic       code_protect_flag;
    logic [3:0] unusedBits;
    logic       data_memory_protect_flag;
    logic       low_voltage_program_enable;
    logic       brownout_enable;
    logic       external_reset_pin_enable;
    logic       osc_select_bit2;
    logic       power_up_delay_enable;
    logic       watchdog_enable;
    logic       osc_select_bit1;
    logic       osc_select_bit0;
  } rcs_cfg_t;
  // one-hot supervisor states
  typedef enum logic [4:0] {
    S_POWER_UP_DELAY_TIMER  = 5'b00001,
    S_OST   = 5'b00010,
    S_RUN   = 5'b00100,
    S_SLEEP = 5'b01000,
    S_HOLD  = 5'b10000
  } rcs_state_t;
endpackage

// *** core/rcs_supervisor.sv ***
// reset, watchdog and sleep supervisor with configuration word
// assumes synchronous inputs, watchdog RC ticks as one-cycle pulses
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module rcs_supervisor #(
  parameter int POWER_UP_DELAY_TIMER_CYCLES = rcs_pkg::POWER_UP_DELAY_TIMER_CYC  // shorten for simulation
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,       // power-on reset
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 progMode,      // programmer has entered programming
  input  wire logic                 brownOutDet,   // supply below trip level
  input  wire logic                 extResetPin_n, // external reset pin
  input  wire logic                 wakeIrq,       // pending interrupt
  input  wire logic                 wdtRcTick,     // watchdog RC oscillator tick
  output logic                      coreReset,     // holds the core in reset
  output logic                      sleeping,
  output logic                      irq,
  output rcs_pkg::rcs_cfg_t         cfgActive      // config sampled at last reset
);
  import rcs_pkg::*;

  // bus data-phase tracking
  logic              dpValid_r, dpValid_nxt;   // one wait state pending
  logic              dpWrite_r, dpWrite_nxt;
  logic [15:0]       dpAddr_r, dpAddr_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic              rdyOut_r, rdyOut_nxt;
  // software visible registers
  rcs_cfg_t          cfgWord_r, cfgWord_nxt;   // stored configuration word
  logic [ST_W-1:0]   status_r, status_nxt;
  logic [ST_W-1:0]   mask_r, mask_nxt;
  logic              irq_r, irq_nxt;
  // supervisor state
  rcs_state_t        state_r, state_nxt;
  logic [CNT_W-1:0]  holdCnt_r, holdCnt_nxt;   // power_up_delay_timer / ost counter
  logic [15:0]       wdtCnt_r, wdtCnt_nxt;     // watchdog tick counter
  rcs_cfg_t          cfgAct_r, cfgAct_nxt;
  logic              coreRst_r, coreRst_nxt;
  logic              sleep_r, sleep_nxt;
  // decoded helpers
  logic              addrTake;
  logic              wrCtrl;
  logic              wrStat;
  logic              inCfgSpace;
  logic              wdtOn;
  logic              wdtFire;
  logic              borHit;
  logic              extHit;
  logic              progMode_r;               // programming mode one cycle ago
  logic              progExit;                 // programmer has just left
  logic [ST_W-1:0]   evt;
  logic [13:0]       cfgIdx;

  localparam logic [CNT_W-1:0] POWER_UP_DELAY_TIMER_LAST = CNT_W'(POWER_UP_DELAY_TIMER_CYCLES - 1);
  localparam logic [CNT_W-1:0] OST_LAST  = CNT_W'(OST_CYC - 1);
  localparam logic [15:0]      WDT_LAST  = 16'(WDT_TICKS - 1);

  // address phase accepted when selected, non-idle and bus ready
  assign addrTake = hsel && htrans[1] && hready;
  assign cfgIdx   = dpAddr_r[15:2];
  // config space only in programming mode; outside it reads as zero
  assign inCfgSpace = progMode && (cfgIdx >= CFG_SPACE_LO)
                      && (cfgIdx <= CFG_SPACE_HI);
  assign wrCtrl = dpValid_r && dpWrite_r && (dpAddr_r == ADDR_CTRL);
  assign wrStat = dpValid_r && dpWrite_r && (dpAddr_r == ADDR_STATUS);

  // options are selected by a programmed (zero) bit
  assign wdtOn  = !cfgAct_r.watchdog_enable;
  assign borHit = !cfgAct_r.brownout_enable && brownOutDet;
  assign extHit = !cfgAct_r.external_reset_pin_enable
                  && !extResetPin_n;
  // leaving programming mode restarts the core on the new word, since
  // the stored word is otherwise only sampled at power-on, watchdog, brown-out and pin resets
  assign progExit = progMode_r && !progMode;
  // watchdog counts only its own RC ticks, never the system clock
  assign wdtFire = wdtOn && wdtRcTick && (wdtCnt_r == WDT_LAST);

  // bus next-state: every transfer gets one wait state, so a write
  // lands before any following read samples the registers
  always_comb begin
    dpValid_nxt = 1'b0;
    dpWrite_nxt = dpWrite_r;
    dpAddr_nxt  = dpAddr_r;
    rdata_nxt   = rdata_r;
    rdyOut_nxt  = 1'b1;
    cfgWord_nxt = cfgWord_r;
    mask_nxt    = mask_r;
    if (addrTake && rdyOut_r) begin
      // capture address phase, stall the data phase one cycle
      dpValid_nxt = 1'b1;
      dpWrite_nxt = hwrite;
      dpAddr_nxt  = haddr[15:0];
      rdyOut_nxt  = 1'b0;
    end
    if (dpValid_r && dpWrite_r) begin
      // write side effects; unmapped addresses are ignored
      if (dpAddr_r == ADDR_MASK) begin
        mask_nxt = hwdata[ST_W-1:0];
      end
      if (inCfgSpace && cfgIdx == CFG_INDEX) begin
        cfgWord_nxt = rcs_cfg_t'(hwdata[13:0]);
      end
    end
    if (dpValid_r && !dpWrite_r) begin
      // read mux; narrow registers sit in the low bits
      rdata_nxt = 32'h0000_0000;
      unique case (1'b1)
        dpAddr_r == ADDR_CTRL:   rdata_nxt = 32'h0000_0000;
        dpAddr_r == ADDR_STATUS: rdata_nxt[ST_W-1:0] = status_r;
        dpAddr_r == ADDR_MASK:   rdata_nxt[ST_W-1:0] = mask_r;
        dpAddr_r == ADDR_STATE: begin
          rdata_nxt[4:0]   = state_r;
          rdata_nxt[5]     = coreRst_r;
          rdata_nxt[6]     = sleep_r;
          rdata_nxt[29:16] = cfgAct_r;
        end
        inCfgSpace && cfgIdx == CFG_INDEX:
          rdata_nxt[13:0] = cfgWord_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dpValid_r <= 1'b0;
      dpWrite_r <= 1'b0;
      dpAddr_r  <= 16'h0000;
      rdata_r   <= 32'h0000_0000;
      rdyOut_r  <= 1'b1;
      mask_r    <= '0;
    end else begin
      dpValid_r <= dpValid_nxt;
      dpWrite_r <= dpWrite_nxt;
      dpAddr_r  <= dpAddr_nxt;
      rdata_r   <= rdata_nxt;
      rdyOut_r  <= rdyOut_nxt;
      mask_r    <= mask_nxt;
    end
  end

  // the stored word is non-volatile in the real part; here it keeps
  // its value across every reset except power-on, which erases it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfgWord_r <= CFG_RESET;
    end else begin
      cfgWord_r <= cfgWord_nxt;
    end
  end

  // status events: one per cause, set wins over write-one-clear
  always_comb begin
    evt          = '0;
    evt[ST_BOR]  = borHit && !state_r[4];
    evt[ST_EXT]  = extHit && !state_r[4];
    evt[ST_WDT]  = wdtFire && state_r == S_RUN;
    evt[ST_WAKE] = state_r == S_SLEEP && (wakeIrq || wdtFire)
                   && !borHit && !extHit;
    status_nxt = status_r;
    if (wrStat) begin
      status_nxt = status_r & ~hwdata[ST_W-1:0];
    end
    status_nxt = status_nxt | evt;
    irq_nxt    = |(status_nxt & mask_r);
  end

  // status and interrupt registers; power-on sets its own bit
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= ST_W'(1 << ST_POR);
      irq_r    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_r    <= irq_nxt;
    end
  end

  // supervisor next-state
  always_comb begin
    state_nxt   = state_r;
    holdCnt_nxt = holdCnt_r + CNT_W'(1);
    wdtCnt_nxt  = wdtCnt_r;
    cfgAct_nxt  = cfgAct_r;
    coreRst_nxt = 1'b1;
    sleep_nxt   = 1'b0;
    if (wdtOn && wdtRcTick) begin
      wdtCnt_nxt = wdtCnt_r + 16'h0001;
    end
    if (wrCtrl && hwdata[CTRL_KICK]) begin
      wdtCnt_nxt = 16'h0000;
    end
    unique case (state_r)
      S_POWER_UP_DELAY_TIMER: begin
        // hold for the power-up delay only after power-on
        if (cfgAct_r.power_up_delay_enable
            || holdCnt_r >= POWER_UP_DELAY_TIMER_LAST) begin
          state_nxt   = S_OST;
          holdCnt_nxt = '0;
        end
      end
      S_OST: begin
        // let the oscillator settle before the core runs
        wdtCnt_nxt = 16'h0000;
        if (holdCnt_r >= OST_LAST) begin
          state_nxt   = S_RUN;
          coreRst_nxt = 1'b0;
        end
      end
      S_RUN: begin
        coreRst_nxt = 1'b0;
        if (wdtFire) begin
          // watchdog timeout while awake resets the core
          state_nxt   = S_OST;
          holdCnt_nxt = '0;
          coreRst_nxt = 1'b1;
          wdtCnt_nxt  = 16'h0000;
          cfgAct_nxt  = cfgWord_r;
        end else if (wrCtrl && hwdata[CTRL_SLEEP]) begin
          state_nxt   = S_SLEEP;
          sleep_nxt   = 1'b1;
          wdtCnt_nxt  = 16'h0000;
        end
      end
      S_SLEEP: begin
        // sleep holds the core in reset; wake restarts the clock before releasing it
        sleep_nxt = 1'b1;
        if (wakeIrq || wdtFire) begin
          state_nxt   = S_OST;
          holdCnt_nxt = '0;
          sleep_nxt   = 1'b0;
          wdtCnt_nxt  = 16'h0000;
        end
      end
      S_HOLD: begin
        // stay while the cause lasts; no power-up delay afterwards
        holdCnt_nxt = '0;
        cfgAct_nxt  = cfgWord_r;
        if (!borHit && !extHit) begin
          state_nxt = S_OST;
        end
      end
    endcase
    // brown-out and pin reset win over every other state
    if ((borHit || extHit) && state_r != S_HOLD) begin
      state_nxt   = S_HOLD;
      holdCnt_nxt = '0;
      coreRst_nxt = 1'b1;
      sleep_nxt   = 1'b0;
      wdtCnt_nxt  = 16'h0000;
    end
    // programmer exit: reload the active config under reset, no power_up_delay_timer
    if (progExit) begin
      state_nxt   = S_OST;
      holdCnt_nxt = '0;
      coreRst_nxt = 1'b1;
      sleep_nxt   = 1'b0;
      wdtCnt_nxt  = 16'h0000;
      cfgAct_nxt  = cfgWord_r;
    end
  end

  // supervisor registers; the first cycle after power-on loads the
  // active config because async reset may not copy a signal
  logic cfgLoaded_r;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r     <= S_POWER_UP_DELAY_TIMER;
      holdCnt_r   <= '0;
      wdtCnt_r    <= 16'h0000;
      cfgAct_r    <= CFG_RESET;
      cfgLoaded_r <= 1'b0;
      coreRst_r   <= 1'b1;
      sleep_r     <= 1'b0;
      progMode_r  <= 1'b0;
    end else begin
      progMode_r  <= progMode;
      state_r     <= cfgLoaded_r ? state_nxt : S_POWER_UP_DELAY_TIMER;
      holdCnt_r   <= cfgLoaded_r ? holdCnt_nxt : '0;
      wdtCnt_r    <= wdtCnt_nxt;
      cfgAct_r    <= cfgLoaded_r ? cfgAct_nxt : cfgWord_r;
      cfgLoaded_r <= 1'b1;
      coreRst_r   <= cfgLoaded_r ? coreRst_nxt : 1'b1;
      sleep_r     <= sleep_nxt;
    end
  end

  // outputs straight from flops, hresp tied low; protection flags only travel out
  // in cfgActive, the core's own EEPROM path never looks at them
  assign hrdata    = rdata_r;
  assign hreadyout = rdyOut_r;
  assign hresp     = 1'b0;   // always OKAY
  assign coreReset = coreRst_r;
  assign sleeping  = sleep_r;
  assign irq       = irq_r;
  assign cfgActive = cfgAct_r;
endmodule

// *** verification/rcs_checker.sv ***
// port-level checker of the supervisor, bound onto rcs_supervisor
// assumes one clock, reset_n asynchronous active low
`timescale 1ns/1ps
module rcs_checker
  import rcs_pkg::*;
#(
  parameter int POWER_UP_DELAY_TIMER_CYCLES = 20  // same power-up hold as the bound design
) (
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic              hsel,
  input wire logic [1:0]        htrans,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  input wire logic              brownOutDet,
  input wire logic              extResetPin_n,
  input wire logic              wakeIrq,
  input wire logic              coreReset,
  input wire logic              sleeping,
  input wire rcs_pkg::rcs_cfg_t cfgActive
);
  localparam int OST_MIN = 1020;  // a few cycles of slack for state hand-over
  logic [15:0] hiCnt_r;           // length of the current reset hold
  logic [15:0] hiCnt_nxt;
  // saturating count, so a stuck reset cannot wrap and look short
  always_comb begin
    hiCnt_nxt = coreReset ? (hiCnt_r + {15'h0000, ~&hiCnt_r}) : 16'h0000;
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hiCnt_r <= 16'h0000;
    end else begin
      hiCnt_r <= hiCnt_nxt;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_take; hsel && htrans[1] && hready && hreadyout |=> !hreadyout; endproperty
  a_take: assert property (p_take) else $error("transfer not stalled");
  property p_wait; !hreadyout |=> hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("wait longer than one cycle");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_cfg; $changed(cfgActive) |-> coreReset; endproperty
  a_cfg: assert property (p_cfg) else $error("config changed outside reset");
  property p_bor; brownOutDet && !cfgActive.brownout_enable |-> ##[1:2] coreReset; endproperty
  a_bor: assert property (p_bor) else $error("brown-out gave no reset");
  property p_pin;
    !extResetPin_n && !cfgActive.external_reset_pin_enable |-> ##[1:2] coreReset;
  endproperty
  a_pin: assert property (p_pin) else $error("pin gave no reset");
  property p_wake; sleeping && wakeIrq |-> ##[1:3] !sleeping; endproperty
  a_wake: assert property (p_wake) else $error("no wake on interrupt");
  property p_ost; $fell(coreReset) |-> hiCnt_r >= OST_MIN; endproperty
  a_ost: assert property (p_ost) else $error("reset hold too short");
  c_sleep: cover property (sleeping && wakeIrq);
  c_bor: cover property (brownOutDet && !cfgActive.brownout_enable);
  c_wait: cover property (!hreadyout);
endmodule
bind rcs_supervisor rcs_checker #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_CYCLES)) chk_u (.clk_sys, .reset_n,
  .hsel, .htrans, .hready, .hreadyout, .hresp, .hrdata, .brownOutDet, .extResetPin_n,
  .wakeIrq, .coreReset, .sleeping, .cfgActive);

// *** verification/rcs_programmer.sv ***
// model of the external programmer's mode line
// assumes the bench issues the bus writes while the mode is held
`timescale 1ns/1ps
module rcs_programmer (
  input wire logic clk_sys,
  output logic     progMode  // high while programming mode is entered
);
  initial progMode = 1'b0;
  // mode changes only after an edge, never mid-transfer
  task automatic setMode(input logic on);
    @(posedge clk_sys) progMode <= on;
  endtask
endmodule

// *** verification/tb.sv ***
// self-checking bench of the supervisor over its register bus
// assumes rcs_pkg, rcs_supervisor, rcs_programmer and the checker
`timescale 1ns/1ps
module tb;
  import rcs_pkg::*;
  localparam int POWER_UP_DELAY_TIMER_T = 2000;  // longer than one start-up hold
  logic        clk_sys, reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdV;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        progMode, brownOutDet, extResetPin_n, wakeIrq, wdtRcTick;
  logic        coreReset, sleeping, irq;
  rcs_cfg_t    cfgActive;
  int          n_fail, checks, c;
  assign hready = hreadyout;  // single slave
  rcs_supervisor #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_T)) dut_u (.clk_sys, .reset_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .progMode,
    .brownOutDet, .extResetPin_n, .wakeIrq, .wdtRcTick, .coreReset, .sleeping, .irq,
    .cfgActive);
  rcs_programmer prog_u (.clk_sys, .progMode);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic close_out();
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // hready seen mid-cycle equals the value taken at the next edge
  task automatic waitRdy();
    int n = 0;
    @(negedge clk_sys);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 50) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    waitRdy();
    @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    waitRdy();
    rdV = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0000_0000);
    chk(rdV, e);
  endtask
  // sel 0 watches coreReset, 1 watches sleeping; c gives the wait
  task automatic waitFor(input bit sel, input logic lvl);
    c = 0;
    @(negedge clk_sys);
    while (((sel ? sleeping : coreReset) !== lvl) && c < 6000) begin
      @(negedge clk_sys);
      c++;
    end
    if (c >= 6000) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge clk_sys) wdtRcTick <= 1'b1;
      @(posedge clk_sys) wdtRcTick <= 1'b0;
    end
  endtask
  initial begin
    #800000;
    n_fail++;
    close_out();
  end
  initial begin
    {hsel, hwrite, brownOutDet, wakeIrq, wdtRcTick} = 5'h00;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    extResetPin_n = 1'b1;
    reset_n = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    waitFor(0, 1'b0);
    chk(32'(c >= 1024 && c < POWER_UP_DELAY_TIMER_T), 32'h1);
    rd(ADDR_STATE, 32'h3FFF_0004);
    rd(ADDR_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(32'h0000_0040, 32'h0);
    rd(32'h0000_801C, 32'h0);
    prog_u.setMode(1'b1);
    wr(32'h0000_801C, 32'h3F93);
    rd(32'h0000_801C, 32'h3F93);
    prog_u.setMode(1'b0);
    rd(32'h0000_801C, 32'h0);
    chk({31'h0, coreReset}, 32'h1);
    waitFor(0, 1'b0);
    chk({18'h0, cfgActive}, 32'h3F93);
    wr(ADDR_STATUS, 32'h1F);
    @(posedge clk_sys) extResetPin_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    extResetPin_n <= 1'b1;
    waitFor(0, 1'b0);
    chk(32'(c < POWER_UP_DELAY_TIMER_T), 32'h1);
    chk({18'h0, cfgActive}, 32'h3F93);
    chk({31'h0, cfgActive.brownout_enable}, 32'h0);
    rd(ADDR_STATUS, 32'h8);
    wr(ADDR_STATUS, 32'h1F);
    @(posedge clk_sys) brownOutDet <= 1'b1;
    repeat (3) @(posedge clk_sys);
    brownOutDet <= 1'b0;
    waitFor(0, 1'b0);
    rd(ADDR_STATUS, 32'h2);
    wr(ADDR_STATUS, 32'h1F);
    ticks(2047);
    chk({31'h0, coreReset}, 32'h0);
    ticks(1);
    repeat (3) @(negedge clk_sys);
    chk({31'h0, coreReset}, 32'h1);
    waitFor(0, 1'b0);
    rd(ADDR_STATUS, 32'h4);
    wr(ADDR_STATUS, 32'h1F);
    wr(ADDR_MASK, 32'h10);
    wr(ADDR_CTRL, 32'h1);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, sleeping}, 32'h1);
    @(posedge clk_sys) wakeIrq <= 1'b1;
    waitFor(1, 1'b0);
    @(posedge clk_sys) wakeIrq <= 1'b0;
    waitFor(0, 1'b0);
    rd(ADDR_STATUS, 32'h10);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_STATUS, 32'h10);
    repeat (2) @(negedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    close_out();
  end
endmodule
